// >>> rtl/cache_coherency_write_ordering.sv
// Cache line states, flush walks and write ordering with an APB register port
`timescale 1ns/1ns
`include "cc_params.svh"
module cache_coherency_write_ordering import cc_pkg::*; #(
  parameter int LINES = 8 // Lines in each cache
) (
  input wire logic CORE_CLK, // Core clock, 10 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic ACC_VALID, // Core access request
  output logic ACC_READY, // Access taken when high with valid
  input wire logic ACC_WRITE, // Access is a write
  input wire logic ACC_IFETCH, // Instruction fetch miss
  input wire logic [1:0] ACC_RANGE, // Memory range type
  input wire logic [31:0] ACC_ADDR, // Access byte address
  input wire logic [31:0] ACC_DATA, // Access write data
  input wire logic [3:0] ACC_BE, // Access byte enables
  output logic BUS_REQ, // Bus cycle request
  output logic BUS_WRITE, // Bus cycle is a write
  output logic BUS_BURST, // Bus cycle is a 32-byte burst
  output logic [31:0] BUS_ADDR, // Bus cycle address
  output logic [63:0] BUS_DATA, // Bus single-cycle data
  output logic [7:0] BUS_BE, // Bus single-cycle byte enables
  input wire logic BUS_ACK, // Bus cycle finished
  input wire logic FLUSH_N, // Flush pin, active low
  input wire logic ADDR_BIT20_MASK_N, // Address bit 20 mask, active low
  input wire logic EXT_WRITE_BUF_EMPTY_N, // External buffer empty, active low
  output logic BUSY // Flush or invalidate walk running
);
  localparam int IDX_W = $clog2(LINES);
  localparam int TAG_W = 32 - `LINE_LSB - IDX_W;

  // Lines must be a power of two for the index split
  generate
    if (LINES < 2 || (LINES & (LINES - 1)) != 0) begin : g_chk
      $error("LINES must be a power of two of at least 2");
    end
  endgenerate

  function automatic logic [IDX_W-1:0] idx_of(input logic [31:0] a);
    return a[`LINE_LSB +: IDX_W];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[31 -: TAG_W];
  endfunction

  function automatic logic [31:0] line_addr(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i);
    return {t, i, {`LINE_LSB{1'b0}}};
  endfunction

  function automatic logic page_hit(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i,
                                    input logic [31:`PAGE_LSB] pg);
    logic [31:0] a;
    a = line_addr(t, i);
    return a[31:`PAGE_LSB] == pg;
  endfunction

  // Cache state held per index, one tag per cache
  mesi_t l1d_st [LINES]; // Data cache line states
  mesi_t l2_st [LINES]; // Second-level line states
  logic l1i_v [LINES]; // Instruction cache valid bits
  logic [TAG_W-1:0] l1d_tag [LINES]; // Data cache tags
  logic [TAG_W-1:0] l2_tag [LINES]; // Second-level tags
  logic [TAG_W-1:0] l1i_tag [LINES]; // Instruction cache tags

  seq_t st_reg; // Sequencer state
  seq_t ret_reg; // State after the bus cycle
  logic gdis_reg; // Global ordering disable
  logic sdis_reg; // Speculative ordering disable
  logic [31:`PAGE_LSB] page_reg; // Page for page flush
  logic page_mode_reg; // 1: invalidate only
  logic page_req_reg; // Page walk pending
  logic wbinv_req_reg; // Full writeback-invalidate pending
  logic inv_req_reg; // Plain invalidate pending
  logic wait_empty_reg; // Drained, awaiting empty input
  logic walk_wb_reg; // Walk performs writebacks
  logic walk_page_reg; // Walk limited to page
  logic walk_pass_reg; // 0: writeback pass, 1: invalidate pass
  logic [IDX_W-1:0] walk_idx_reg; // Walk index
  logic merge_bus_reg; // Bus cycle drains merge buffer
  logic acc_write_reg; // Latched access fields
  logic acc_ifetch_reg;
  logic [1:0] acc_range_reg;
  logic [31:0] acc_addr_reg;
  logic [31:0] acc_data_reg;
  logic [3:0] acc_be_reg;
  logic ctrl_written_reg; // Ordering bits written since reset
  logic mb_valid, mb_can_merge; // Merge buffer status
  logic [31:0] mb_addr;
  logic [63:0] mb_data;
  logic [7:0] mb_be;

  // APB decode
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  wire apb_mapped = (PADDR == `OFF_ORDER) | (PADDR == `OFF_PAGE) | (PADDR == `OFF_CMD) | (PADDR == `OFF_STATUS);

  // Access decode on the latched, already masked address
  wire [IDX_W-1:0] ai = idx_of(acc_addr_reg);
  wire [TAG_W-1:0] at = tag_of(acc_addr_reg);
  wire d_hit = (l1d_st[ai] != MESI_I) & (l1d_tag[ai] == at);
  wire l2_hit = (l2_st[ai] != MESI_I) & (l2_tag[ai] == at);
  wire i_hit = l1i_v[ai] & (l1i_tag[ai] == at);
  wire d_wb_mode = d_hit & (l1d_st[ai] == MESI_M | l1d_st[ai] == MESI_E);
  wire uncached = acc_range_reg != `RNG_NORMAL;
  wire combine_wr = acc_write_reg & (acc_range_reg == `RNG_COMBINE);
  wire [63:0] wt_data = acc_addr_reg[2] ? {acc_data_reg, 32'h0000_0000} : {32'h0000_0000, acc_data_reg};
  wire [7:0] wt_be = acc_addr_reg[2] ? {acc_be_reg, 4'h0} : {4'h0, acc_be_reg};

  // Commit gate for writes to M/E lines
  wire hold = ~gdis_reg & (EXT_WRITE_BUF_EMPTY_N | (~sdis_reg & wait_empty_reg));
  wire order_mb = ~gdis_reg & ~sdis_reg & mb_valid;

  // Walk decode; the page test uses the stored tag, never the masked address
  wire [IDX_W-1:0] wi = walk_idx_reg;
  wire w_d_m = ~walk_page_reg | page_hit(l1d_tag[wi], wi, page_reg);
  wire w_2_m = ~walk_page_reg | page_hit(l2_tag[wi], wi, page_reg);
  wire w_i_m = ~walk_page_reg | page_hit(l1i_tag[wi], wi, page_reg);

  wire take = ACC_VALID & ACC_READY;
  wire walk_go = ~FLUSH_N | page_req_reg | wbinv_req_reg | inv_req_reg;
  wire walk_start = (st_reg == ST_IDLE) & ~take & walk_go;
  wire mb_push = (st_reg == ST_EXEC) & uncached & combine_wr & (~mb_valid | mb_can_merge);
  wire mb_take = (st_reg == ST_BUS) & BUS_ACK & merge_bus_reg;
  wire walk_wb_n = ~FLUSH_N | (page_req_reg & ~page_mode_reg) | (~page_req_reg & wbinv_req_reg);
  wire walk_page_n = FLUSH_N & page_req_reg;

  merge_buffer #(.BYTES(`MB_BYTES)) u_mb (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .push(mb_push),
    .push_addr(acc_addr_reg),
    .push_data(acc_data_reg),
    .push_be(acc_be_reg),
    .take(mb_take),
    .valid(mb_valid),
    .can_merge(mb_can_merge),
    .out_addr(mb_addr),
    .out_data(mb_data),
    .out_be(mb_be)
  );

  // APB answer: ready in the first access cycle, read data captured at setup
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~apb_mapped;
      if (apb_setup & ~PWRITE) begin
        PRDATA <= 32'h0000_0000;
        case (PADDR)
          `OFF_ORDER: begin
            PRDATA[`ORD_GLOB_BIT] <= gdis_reg;
            PRDATA[`ORD_SPEC_BIT] <= sdis_reg;
          end
          `OFF_PAGE: begin
            PRDATA[31:`PAGE_LSB] <= page_reg;
            PRDATA[`PAGE_MODE_BIT] <= page_mode_reg;
          end
          `OFF_CMD: begin
            PRDATA[`CMD_WBINV_BIT] <= wbinv_req_reg;
            PRDATA[`CMD_INV_BIT] <= inv_req_reg;
          end
          `OFF_STATUS: begin
            PRDATA[`STAT_BUSY] <= BUSY;
            PRDATA[`STAT_MB_VALID] <= mb_valid;
            PRDATA[`STAT_WAIT_EMPTY] <= wait_empty_reg;
            PRDATA[`STAT_HOLD] <= hold;
            PRDATA[`STAT_A20] <= ~ADDR_BIT20_MASK_N;
          end
          default: begin
            PRDATA <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Software control: ordering bits and walk requests; a new request beats the start that clears it
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gdis_reg <= `ORD_RESET;
      sdis_reg <= `ORD_RESET;
      ctrl_written_reg <= 1'b0;
      page_reg <= '0;
      page_mode_reg <= 1'b0;
      page_req_reg <= 1'b0;
      wbinv_req_reg <= 1'b0;
      inv_req_reg <= 1'b0;
    end else begin
      if (walk_start) begin
        // Flush pin takes priority; the request it overtakes stays pending
        if (FLUSH_N & page_req_reg) begin
          page_req_reg <= 1'b0;
        end else if (FLUSH_N & wbinv_req_reg) begin
          wbinv_req_reg <= 1'b0;
        end else if (FLUSH_N) begin
          inv_req_reg <= 1'b0;
        end
      end
      if (apb_wr && PADDR == `OFF_ORDER) begin
        gdis_reg <= PWDATA[`ORD_GLOB_BIT];
        sdis_reg <= PWDATA[`ORD_SPEC_BIT];
        ctrl_written_reg <= 1'b1;
      end
      // Writes while a walk runs are still queued, but a running page walk tests its remaining lines against the new page
      if (apb_wr && PADDR == `OFF_PAGE) begin
        page_reg <= PWDATA[31:`PAGE_LSB];
        page_mode_reg <= PWDATA[`PAGE_MODE_BIT];
        page_req_reg <= 1'b1;
      end
      if (apb_wr && PADDR == `OFF_CMD) begin
        if (PWDATA[`CMD_WBINV_BIT]) wbinv_req_reg <= 1'b1;
        if (PWDATA[`CMD_INV_BIT]) inv_req_reg <= 1'b1;
      end
    end
  end

  // Drain seen in full-order mode; the empty input must be seen asserted afterwards
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_empty_reg <= 1'b0;
    end else if (mb_take & ~gdis_reg & ~sdis_reg) begin
      wait_empty_reg <= 1'b1;
    end else if (!EXT_WRITE_BUF_EMPTY_N) begin
      wait_empty_reg <= 1'b0;
    end
  end

  // Start a bus cycle and name where the sequencer resumes
  task automatic go_bus(input logic wr, input logic burst, input logic [31:0] a,
                        input logic [63:0] d, input logic [7:0] be, input seq_t r);
    BUS_REQ <= 1'b1;
    BUS_WRITE <= wr;
    BUS_BURST <= burst;
    BUS_ADDR <= a;
    BUS_DATA <= d;
    BUS_BE <= be;
    ret_reg <= r;
    st_reg <= ST_BUS;
  endtask

  // Sequencer: accesses, bus cycles, walks and the line arrays
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      ACC_READY <= 1'b0;
      BUSY <= 1'b0;
      BUS_REQ <= 1'b0;
      BUS_WRITE <= 1'b0;
      BUS_BURST <= 1'b0;
      BUS_ADDR <= 32'h0000_0000;
      BUS_DATA <= '0;
      BUS_BE <= 8'h00;
      merge_bus_reg <= 1'b0;
      walk_wb_reg <= 1'b0;
      walk_page_reg <= 1'b0;
      walk_pass_reg <= 1'b0;
      walk_idx_reg <= '0;
      acc_write_reg <= 1'b0;
      acc_ifetch_reg <= 1'b0;
      acc_range_reg <= `RNG_NORMAL;
      acc_addr_reg <= 32'h0000_0000;
      acc_data_reg <= 32'h0000_0000;
      acc_be_reg <= 4'h0;
      for (int k = 0; k < LINES; k++) begin
        l1d_st[k] <= MESI_I;
        l2_st[k] <= MESI_I;
        l1i_v[k] <= 1'b0;
        l1d_tag[k] <= '0;
        l2_tag[k] <= '0;
        l1i_tag[k] <= '0;
      end
    end else begin
      ACC_READY <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (take) begin
            // Mask sampled as a level on the taking edge, applied before the tags
            acc_addr_reg <= ACC_ADDR & ~({31'h0000_0000, ~ADDR_BIT20_MASK_N} << `A20_BIT);
            acc_write_reg <= ACC_WRITE;
            acc_ifetch_reg <= ACC_IFETCH;
            acc_range_reg <= ACC_RANGE;
            acc_data_reg <= ACC_DATA;
            acc_be_reg <= ACC_BE;
            st_reg <= ST_EXEC;
          end else if (walk_go) begin
            walk_wb_reg <= walk_wb_n;
            walk_page_reg <= walk_page_n;
            walk_pass_reg <= ~walk_wb_n;
            walk_idx_reg <= '0;
            BUSY <= 1'b1;
            st_reg <= ST_WALK;
          end else if (mb_valid & ~ACC_VALID) begin
            // Drain only when the core is quiet so back-to-back stores can merge
            merge_bus_reg <= 1'b1;
            go_bus(1'b1, 1'b0, mb_addr, mb_data, mb_be, ST_IDLE);
          end else begin
            ACC_READY <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (uncached) begin
            if (mb_valid && !(combine_wr && mb_can_merge)) begin
              // Older buffered data goes out first
              merge_bus_reg <= 1'b1;
              go_bus(1'b1, 1'b0, mb_addr, mb_data, mb_be, ST_EXEC);
            end else if (combine_wr) begin
              st_reg <= ST_IDLE;
            end else begin
              go_bus(acc_write_reg, 1'b0, acc_addr_reg, wt_data, wt_be, ST_IDLE);
            end
          end else if (acc_ifetch_reg) begin
            // Instruction miss snoops the data cache
            l1i_v[ai] <= 1'b1;
            l1i_tag[ai] <= at;
            if (d_hit) l1d_st[ai] <= MESI_I;
            if (d_hit && l1d_st[ai] == MESI_M) begin
              if (l2_hit && (l2_st[ai] == MESI_E || l2_st[ai] == MESI_M)) begin
                l2_st[ai] <= MESI_M;
                st_reg <= ST_IDLE;
              end else begin
                go_bus(1'b1, 1'b1, line_addr(l1d_tag[ai], ai), '0, 8'hFF, ST_IDLE);
              end
            end else begin
              st_reg <= ST_IDLE;
            end
          end else begin
            // Data misses snoop the instruction cache
            if (i_hit && !d_hit) l1i_v[ai] <= 1'b0;
            if (acc_write_reg) begin
              if (d_wb_mode) begin
                if (order_mb) begin
                  merge_bus_reg <= 1'b1;
                  go_bus(1'b1, 1'b0, mb_addr, mb_data, mb_be, ST_EXEC);
                end else if (!hold) begin
                  l1d_st[ai] <= MESI_M;
                  st_reg <= ST_IDLE;
                end
              end else begin
                go_bus(1'b1, 1'b0, acc_addr_reg, wt_data, wt_be, ST_IDLE);
              end
            end else if (d_hit) begin
              st_reg <= ST_IDLE;
            end else if (l1d_st[ai] == MESI_M) begin
              // Victim holds modified data: burst it out before the refill
              l1d_st[ai] <= MESI_I;
              go_bus(1'b1, 1'b1, line_addr(l1d_tag[ai], ai), '0, 8'hFF, ST_EXEC);
            end else if (l2_hit) begin
              l1d_st[ai] <= (l2_st[ai] == MESI_M) ? MESI_S : MESI_E;
              l1d_tag[ai] <= at;
              st_reg <= ST_IDLE;
            end else begin
              l1d_st[ai] <= MESI_E;
              l1d_tag[ai] <= at;
              go_bus(1'b0, 1'b1, line_addr(at, ai), '0, 8'hFF, ST_IDLE);
            end
          end
        end
        ST_BUS: begin
          if (BUS_ACK) begin
            BUS_REQ <= 1'b0;
            merge_bus_reg <= 1'b0;
            st_reg <= ret_reg;
          end
        end
        ST_WALK: begin
          if (!walk_pass_reg && l2_st[wi] == MESI_M && w_2_m) begin
            // Second level first, so the newer data cache copy lands last
            l2_st[wi] <= MESI_E;
            go_bus(1'b1, 1'b1, line_addr(l2_tag[wi], wi), '0, 8'hFF, ST_WALK);
          end else if (!walk_pass_reg && l1d_st[wi] == MESI_M && w_d_m) begin
            l1d_st[wi] <= MESI_E;
            go_bus(1'b1, 1'b1, line_addr(l1d_tag[wi], wi), '0, 8'hFF, ST_WALK);
          end else begin
            if (walk_pass_reg) begin
              if (w_d_m) l1d_st[wi] <= MESI_I;
              if (w_2_m) l2_st[wi] <= MESI_I;
              if (w_i_m) l1i_v[wi] <= 1'b0;
            end
            walk_idx_reg <= walk_idx_reg + 1'b1;
            if (walk_idx_reg == IDX_W'(LINES - 1)) begin
              walk_pass_reg <= 1'b1;
              if (walk_pass_reg) begin
                BUSY <= 1'b0;
                st_reg <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_snoop_inval: assert property ((st_reg == ST_EXEC && !uncached && acc_ifetch_reg && d_hit)
    |=> l1d_st[$past(ai)] == MESI_I) else $error("snoop left data line valid");
  chk_wb_burst: assert property ((st_reg == ST_BUS && ret_reg == ST_WALK) |-> BUS_BURST && BUS_WRITE)
    else $error("walk writeback not a burst");
  chk_no_e_over_m: assert property (!(l1d_st[ai] == MESI_E && l2_st[ai] == MESI_M
    && l1d_tag[ai] == l2_tag[ai])) else $error("data exclusive over second-level modified");
  chk_wt_single: assert property ((st_reg == ST_EXEC && !uncached && !acc_ifetch_reg && acc_write_reg
    && !d_wb_mode) |=> BUS_REQ && !BUS_BURST && BUS_WRITE) else $error("writethrough not single");
  chk_a20_masked: assert property ((take && !ADDR_BIT20_MASK_N) |=> !acc_addr_reg[`A20_BIT])
    else $error("bit 20 not masked");
  chk_hold_commit: assert property ((st_reg == ST_EXEC && !uncached && !acc_ifetch_reg && acc_write_reg
    && d_wb_mode && !order_mb && hold) |=> st_reg == ST_EXEC && $stable(l1d_st[ai])) else $error("commit not held");
  chk_global_off: assert property (gdis_reg |-> !hold && !order_mb)
    else $error("ordering active while disabled");
  chk_reset_order: assert property (!ctrl_written_reg |-> !gdis_reg && !sdis_reg)
    else $error("ordering bits not zero after reset");
  chk_walk_busy: assert property ((st_reg == ST_WALK || (st_reg == ST_BUS && ret_reg == ST_WALK))
    |-> BUSY && !ACC_READY) else $error("walk not shown busy");
  chk_inval_nowb: assert property ((st_reg == ST_WALK && !walk_wb_reg) |=> !BUS_REQ)
    else $error("invalidate walk issued a writeback");
endmodule

// >>> rtl/cc_params.svh
// Offsets, field positions and codes for the coherency and write-ordering block
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH
`define OFF_ORDER 8'h00
`define OFF_PAGE 8'h04
`define OFF_CMD 8'h08
`define OFF_STATUS 8'h0C
`define ORD_SPEC_BIT 2
`define ORD_GLOB_BIT 3
`define ORD_RESET 1'b0
`define PAGE_MODE_BIT 0
`define PAGE_LSB 12
`define CMD_WBINV_BIT 0
`define CMD_INV_BIT 1
`define STAT_BUSY 0
`define STAT_MB_VALID 1
`define STAT_WAIT_EMPTY 2
`define STAT_HOLD 3
`define STAT_A20 4
`define LINE_LSB 5
`define A20_BIT 20
`define MB_BYTES 8
`define RNG_NORMAL 2'h0
`define RNG_UNCACHED 2'h1
`define RNG_COMBINE 2'h2
`endif

// >>> rtl/cc_pkg.sv
// Types shared by the coherency and write-ordering block
package cc_pkg;
  typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} mesi_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_BUS, ST_WALK} seq_t;
endpackage

// >>> rtl/merge_buffer.sv
// Eight-byte write merge buffer for write-combining stores
`timescale 1ns/1ns
`include "cc_params.svh"
module merge_buffer #(
  parameter int BYTES = `MB_BYTES // Buffer width in bytes
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic push, // Store one 32-bit write
  input wire logic [31:0] push_addr, // Byte address of the write
  input wire logic [31:0] push_data, // Write data
  input wire logic [3:0] push_be, // Byte enables of the write
  input wire logic take, // Contents went out on the bus
  output logic valid, // Buffer holds data
  output logic can_merge, // Write falls in the held block
  output logic [31:0] out_addr, // Block-aligned address
  output logic [BYTES*8-1:0] out_data, // Merged data
  output logic [BYTES-1:0] out_be // Merged byte enables
);
  localparam int LSB = $clog2(BYTES);

  // Two 32-bit lanes are assumed by the lane select below
  generate
    if (BYTES != 8) begin : g_chk
      $error("merge_buffer serves eight bytes only");
    end
  endgenerate

  logic [31:LSB] blk_reg; // Block held in the buffer
  logic [BYTES*8-1:0] data_next; // Data after this push
  logic [BYTES-1:0] be_next; // Enables after this push

  assign can_merge = valid & (push_addr[31:LSB] == blk_reg);
  assign out_addr = {blk_reg, {LSB{1'b0}}};

  // Lay the new bytes over what is held; a fresh block starts empty
  always_comb begin
    be_next = valid ? out_be : '0;
    data_next = out_data;
    for (int b = 0; b < 4; b++) begin
      if (push_be[b]) begin
        data_next[32*push_addr[2] + 8*b +: 8] = push_data[8*b +: 8];
        be_next[4*push_addr[2] + b] = 1'b1;
      end
    end
  end

  // Buffer storage; a drain empties it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      blk_reg <= '0;
      out_data <= '0;
      out_be <= '0;
    end else if (take) begin
      valid <= 1'b0;
    end else if (push) begin
      valid <= 1'b1;
      blk_reg <= push_addr[31:LSB];
      out_data <= data_next;
      out_be <= be_next;
    end
  end
endmodule

// >>> sim/bus_partner.sv
// System-logic model on the processor bus: acknowledges bus cycles
`timescale 1ns/1ns
module bus_partner #(
  parameter int WAIT_CYC = 2 // Cycles held before acknowledge
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic req, // Bus cycle request
  output logic ack // One-cycle completion pulse
);
  int cnt; // Wait counter
  // Pulse ack once per cycle; it drops at once so one request never ends twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      ack <= 1'b0;
    end else if (req && !ack && cnt >= WAIT_CYC) begin
      cnt <= 0;
      ack <= 1'b1;
    end else begin
      cnt <= req ? cnt + 1 : 0;
      ack <= 1'b0;
    end
  end
endmodule

// >>> sim/tb_cache_coherency_write_ordering.sv
// Bench: ordering bits, commit hold, mask, writethrough and flush walks
`timescale 1ns/1ns
module tb_cache_coherency_write_ordering;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, acc_v = 0, acc_w = 0, flush_n = 1, a20_n = 1, ext_write_buf_empty_n_n = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, acc_a = 0, prdata, bus_a, rd, last_addr, last_dhi;
  logic [7:0] bus_be, last_be;
  logic [63:0] bus_d;
  logic ifet = 0, last_wr;
  logic [1:0] rng = 0;
  logic pready, pslverr, acc_rdy, breq, bwr, bburst, back, busy, err, last_burst;
  int err_count = 0, n_compared = 0, n_bus = 0, nb;
  logic [7:0] pa[5] = '{8'h08, 8'h00, 8'h08, 8'h04, 8'h04}; // Flush kinds; 0x00 means the pin
  logic [31:0] pd[5] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000, 32'h0000_0001};
  int nwb[5] = '{1, 1, 0, 1, 0}; // Writebacks expected per kind
  always #50 clk = ~clk;
  cache_coherency_write_ordering cache_coherency_write_ordering_i (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ACC_VALID(acc_v), .ACC_READY(acc_rdy), .ACC_WRITE(acc_w), .ACC_IFETCH(ifet),
    .ACC_RANGE(rng), .ACC_ADDR(acc_a), .ACC_DATA(32'h1234_5678), .ACC_BE(4'hF), .BUS_REQ(breq),
    .BUS_WRITE(bwr), .BUS_BURST(bburst), .BUS_ADDR(bus_a), .BUS_DATA(bus_d), .BUS_BE(bus_be), .BUS_ACK(back),
    .FLUSH_N(flush_n), .ADDR_BIT20_MASK_N(a20_n), .EXT_WRITE_BUF_EMPTY_N(ext_write_buf_empty_n_n), .BUSY(busy));
  bus_partner bus_partner_i (.clk(clk), .rst_n(rst_n), .req(breq), .ack(back));
  // Log each finished bus cycle
  always @(posedge clk) if (breq === 1'b1 && back === 1'b1) begin
    last_burst <= bburst;
    last_addr <= bus_a;
    last_wr <= bwr;
    last_be <= bus_be;
    last_dhi <= bus_d[63:32];
    n_bus <= n_bus + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Core access, released at the take edge
  task automatic acc(input logic w, input logic [1:0] r, input logic [31:0] a);
    acc_v <= 1'b1;
    acc_w <= w;
    rng <= r;
    acc_a <= a;
    do @(posedge clk); while (acc_rdy !== 1'b1);
    acc_v <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    do @(posedge clk); while (acc_rdy !== 1'b1 || busy === 1'b1);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("order reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    // Negated empty input holds commits unless global disable is set
    ext_write_buf_empty_n_n <= 1'b1;
    foreach (pd[i]) if (i < 4) begin
      apb(1'b1, 8'h00, {28'h0, i[1:0] == 1 ? 4'h8 : i[1:0] == 2 ? 4'hC : i[1:0] == 3 ? 4'h4 : 4'h0});
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("commit hold", {31'h0, i == 0 || i == 3}, {31'h0, rd[3]});
    end
    ext_write_buf_empty_n_n <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0000);
    a20_n <= 1'b0;
    acc(1'b1, 2'h0, 32'h0010_0040);
    wait_idle;
    chk("wt burst", 32'h0, {31'h0, last_burst});
    chk("wt write", 32'h1, {31'h0, last_wr});
    chk("wt be", 32'h0000_000F, {24'h0, last_be});
    chk("masked addr", 32'h0000_0040, last_addr);
    a20_n <= 1'b1;
    // Dirty one line, then flush it each way
    for (int k = 0; k < 5; k++) begin
      acc(1'b0, 2'h0, 32'h0000_0020);
      ext_write_buf_empty_n_n <= (k == 0);
      acc(1'b1, 2'h0, 32'h0000_0020);
      repeat (3) @(posedge clk);
      chk("commit held", {31'h0, k != 0}, {31'h0, acc_rdy});
      ext_write_buf_empty_n_n <= 1'b0;
      wait_idle;
      nb = n_bus;
      if (k == 1) begin
        flush_n <= 1'b0;
        @(posedge clk);
        flush_n <= 1'b1;
      end else begin
        apb(1'b1, pa[k], pd[k]);
      end
      repeat (2) @(posedge clk);
      chk("busy", 32'h1, {31'h0, busy});
      wait_idle;
      chk("wb count", nb + nwb[k], n_bus);
      if (nwb[k] == 1) chk("wb burst", 32'h0000_0021, {last_addr[31:1], last_burst});
    end
    // Two combining stores to one block leave as one single write
    nb = n_bus;
    acc(1'b1, 2'h2, 32'h0000_0100);
    acc(1'b1, 2'h2, 32'h0000_0104);
    wait_idle;
    chk("merge count", nb + 1, n_bus);
    chk("merge be", 32'h0000_00FF, {24'h0, last_be});
    chk("merge data", 32'h1234_5678, last_dhi);
    // Instruction miss on a dirty data line writes it out and drops it
    acc(1'b0, 2'h0, 32'h0000_0020);
    acc(1'b1, 2'h0, 32'h0000_0020);
    wait_idle;
    nb = n_bus;
    ifet <= 1'b1;
    acc(1'b0, 2'h0, 32'h0000_0020);
    ifet <= 1'b0;
    wait_idle;
    chk("snoop wb", nb + 1, n_bus);
    chk("snoop burst", 32'h0000_0021, {last_addr[31:1], last_burst});
    acc(1'b0, 2'h0, 32'h0000_0020);
    wait_idle;
    chk("snoop inval", nb + 2, n_bus);
    give_verdict;
  end
endmodule
